// >>> bench/oavg_spi_host.sv
`timescale 1ns/1ps
`default_nettype none

module oavg_spi_host (
    input wire logic ref_clk,
    input wire logic sdo,
    input wire logic sdo_oe,
    output logic cs_n,
    output logic sclk
);
    // Serial clock stands low between frames
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
    end

    // --------------------------------
    // One read frame, 160 ns serial clock
    // --------------------------------
    task automatic frame(input int nbits, output logic [17:0] data, output logic oe_ok);
        data = 18'h00000;
        oe_ok = 1'b1;
        @(negedge ref_clk);
        cs_n = 1'b0;
        repeat (16) @(negedge ref_clk);
        for (int i = 0; i < nbits; i++)
        begin
            sclk = 1'b1;
            repeat (8) @(negedge ref_clk);
            data = {data[16:0], sdo};
            oe_ok = oe_ok & (sdo_oe === 1'b1);
            sclk = 1'b0;
            repeat (8) @(negedge ref_clk);
        end
        cs_n = 1'b1;
    endtask
endmodule

`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
    import oavg_pkg::*;
;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic cs_n;
    logic sclk;
    logic sdo;
    logic sdo_oe;
    logic conv_start;
    logic result_ready;
    logic [SETUP_W-1:0] setup_word = 16'h0000;
    logic setup_load = 1'b0;
    logic soft_reset_req = 1'b0;
    logic narrow_variant = 1'b0;
    logic conv_done = 1'b0;
    logic [DATA_W-1:0] conv_data = 16'h0000;
    logic [RES_W-1:0] result_word;
    logic [4:0] result_width;
    logic [RES_W-1:0] got_w;
    logic [4:0] got_n;
    logic signed [DATA_W-1:0] fifo [0:7];
    logic signed [DATA_W-1:0] v;
    logic [RES_W-1:0] prev_v = 18'h00000;
    int prev_w = 0;
    int fails = 0;
    int compares = 0;
    int idx = 0;
    int acc = 0;
    int nconv = 0;
    int nstart = 0;
    int lat = 0;
    int cyc = 0;
    int last_start = 0;
    int nres = 0;
    bit refill = 1'b1;

    always #5 ref_clk = ~ref_clk;

    oavg_top uut (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .cs_n(cs_n),
        .sclk(sclk),
        .setup_word(setup_word),
        .setup_load(setup_load),
        .soft_reset_req(soft_reset_req),
        .narrow_variant(narrow_variant),
        .conv_done(conv_done),
        .conv_data(conv_data),
        .conv_start(conv_start),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .result_word(result_word),
        .result_width(result_width),
        .result_ready(result_ready)
    );

    oavg_spi_host host (
        .ref_clk(ref_clk),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .cs_n(cs_n),
        .sclk(sclk)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic logic [31:0] msk(input logic [17:0] x, input int w);
        return 32'(x & ((18'h00001 << w) - 18'h00001));
    endfunction

    // --------------------------------
    // Converter core and sample FIFO mirror
    // --------------------------------
    always @(negedge ref_clk)
    begin
        conv_done <= (conv_start !== 1'b1) && (lat == 1);
        cyc = cyc + 1;
        if (conv_start === 1'b1)
        begin
            if (nstart > 0)
                check(32'(cyc - last_start), 32'(SAMPLE_CYC));
            nstart++;
            last_start = cyc;
            lat = 5;
        end
        else if (lat > 1)
            lat--;
        else if (lat == 1)
        begin
            lat = 0;
            v = 16'((idx * 977 + 31) % 4001 - 2000);
            idx++;
            conv_data <= v;
            acc += int'(v);
            nconv++;
            for (int j = 7; j > 0; j--)
                fifo[j] = refill ? v : fifo[j-1];
            fifo[0] = v;
            refill = 1'b0;
        end
    end

    always @(negedge ref_clk)
        if (result_ready === 1'b1)
        begin
            nres++;
            got_w = result_word;
            got_n = result_width;
        end

    // --------------------------------
    // One frame: read previous result, check new one
    // --------------------------------
    task automatic op(input logic [15:0] sw, input logic nar);
        logic [17:0] d;
        logic ok;
        int c0;
        int n;
        int s;
        int w;
        int code;
        bit va;
        if (sw !== setup_word)
        begin
            if (sw[REFERENCE_SOURCE_SELECT_BIT] != setup_word[REFERENCE_SOURCE_SELECT_BIT])
                refill = 1'b1;
            @(negedge ref_clk);
            setup_word = sw;
            setup_load = 1'b1;
            @(negedge ref_clk);
            setup_load = 1'b0;
            repeat (4) @(negedge ref_clk);
        end
        narrow_variant = nar;
        acc = 0;
        nconv = 0;
        nstart = 0;
        c0 = nres;
        host.frame(prev_w, d, ok);
        if (prev_w != 0)
        begin
            check(32'(d), msk(prev_v, prev_w));
            check(32'(ok), 32'h1);
        end
        for (int t = 0; t < 3000 && nres == c0; t++)
            @(negedge ref_clk);
        if (nres == c0)
        begin
            fails++;
            conclude();
        end
        code = int'(sw[RATIO_HI:RATIO_LO]);
        va = code != 0 && code <= (sw[STYLE_BIT] ? 3 : 5);
        n = 1 << code;
        w = nar ? 14 : 16;
        s = int'(v);
        if (va)
        begin
            if (sw[STYLE_BIT])
            begin
                s = 0;
                for (int j = 0; j < n; j++)
                    s += int'(fifo[j]);
            end
            else
                s = acc;
            if (sw[BOOST_BIT])
            begin
                s = s * 4;
                w = w + 2;
            end
            s = s >>> code;
        end
        check(msk(got_w, w), msk(18'(s), w));
        check(32'(got_n), 32'(w));
        check(32'(nconv), 32'((va && !sw[STYLE_BIT]) ? n : 1));
        prev_v = 18'(s);
        prev_w = w;
    endtask

    initial
    begin
        repeat (12) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (8) @(negedge ref_clk);
        op(16'h0000, 1'b0);
        for (int c = 1; c < 8; c++)
            op(16'(c << 6), 1'b0);
        op(16'h00c4, 1'b0);
        op(16'h0004, 1'b0);
        for (int c = 0; c < 8; c++)
            op(16'h0200 | 16'(c << 6), 1'b0);
        op(16'h0284, 1'b0);
        op(16'h0000, 1'b1);
        op(16'h00c4, 1'b1);
        op(16'h0284, 1'b1);
        @(negedge ref_clk);
        soft_reset_req = 1'b1;
        @(negedge ref_clk);
        soft_reset_req = 1'b0;
        refill = 1'b1;
        prev_w = 0;
        op(16'h0284, 1'b0);
        op(16'h02e0, 1'b0);
        op(16'h02e0, 1'b0);
        conclude();
    end
endmodule

`default_nettype wire

// >>> design/oavg_pkg.sv
package oavg_pkg;

    // --------------------------------------------------------------
    // Widths
    // --------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int RES_W = 18;
    localparam int ACC_W = 21;
    localparam int WK_W = 24;
    localparam int FIFO_DEPTH = 8;
    localparam int SETUP_W = 16;
    localparam int BOOST_BITS = 2;
    localparam logic [4:0] WIDTH_WIDE = 5'h10;
    localparam logic [4:0] WIDTH_NARROW = 5'h0e;

    // --------------------------------------------------------------
    // Setup word fields
    // --------------------------------------------------------------
    localparam int STYLE_BIT = 9;
    localparam int RATIO_HI = 8;
    localparam int RATIO_LO = 6;
    localparam int REFERENCE_SOURCE_SELECT_BIT = 5;
    localparam int BOOST_BIT = 2;
    localparam logic [SETUP_W-1:0] SETUP_RESET = 16'h0000;

    // --------------------------------------------------------------
    // Ratio codes and styles
    // --------------------------------------------------------------
    localparam logic [2:0] RATIO_OFF = 3'h0;
    localparam logic [2:0] RATIO_MAX_NORMAL = 3'h5;
    localparam logic [2:0] RATIO_MAX_ROLLING = 3'h3;
    localparam logic STYLE_NORMAL = 1'b0;
    localparam logic STYLE_ROLLING = 1'b1;

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int SAMPLE_KSPS = 3000;
    localparam int SAMPLE_CYC_I = (CLK_MHZ * 1000 + SAMPLE_KSPS - 1) / SAMPLE_KSPS;
    localparam logic [5:0] SAMPLE_CYC = 6'(SAMPLE_CYC_I);
    localparam logic [5:0] TIMER_MAX = 6'h3f;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_WAIT = 2'b10,
        ST_FINISH = 2'b11
    } oavg_state_t;

endpackage

// >>> design/oavg_sync.sv
`timescale 1ns/1ps
`default_nettype none

module oavg_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);

    logic [1:0] stage_r;

    // --------------------------------------------------------------
    // Two-stage capture; only the second stage leaves
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage_r <= {2{RST_VAL}};
        end
        else
        begin
            stage_r <= {stage_r[0], d};
        end
    end

    assign q = stage_r[1];

endmodule
`default_nettype wire

// >>> design/oavg_top.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Normal average sums n conversions and outputs sum divided by n.
// - Accumulator and count are cleared after every normal-average result.
// - Normal average runs when style bit is 0 and ratio code is valid.
// - A new ratio code reaches the active setting two clocks after writing.
// - Ratio code 000 is off; 001 to 101 give 2, 4, 8, 16, 32.
// - Without boost the result is 16 bits, or 14 on the narrow variant.
// - Chip-select fall starts the first sample; the rest are timed internally.
// - Internal extra samples are spaced at the 3 MSPS interval.
// - A result is shifted out on the access after its starting edge.
// - Rolling average runs when style bit is 1 and ratio code is valid.
// - In rolling mode each chip-select fall starts one conversion into the FIFO.
// - The sample FIFO holds eight entries for any ratio.
// - First conversion after reset or reference toggle fills every FIFO entry.
// - Every conversion enters the FIFO whatever the mode settings are.
// - Rolling average outputs sum of newest n FIFO entries divided by n.
// - Rolling mode keeps the FIFO and gives one result per conversion, codes 1-3.
// - Boost with a valid averaging mode widens the result by two bits.
// - Style bit sits at bit 9, ratio field at bits 8 to 6.
// - Results go out twos complement, most significant bit first.
module oavg_top
    import oavg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic [SETUP_W-1:0] setup_word,
    input wire logic setup_load,
    input wire logic soft_reset_req,
    input wire logic narrow_variant,
    input wire logic conv_done,
    input wire logic [DATA_W-1:0] conv_data,
    output logic conv_start,
    output logic sdo,
    output logic sdo_oe,
    output logic [RES_W-1:0] result_word,
    output logic [4:0] result_width,
    output logic result_ready
);

    typedef struct packed {
        oavg_state_t state;
        logic cs_q;
        logic sclk_q;
        logic [SETUP_W-1:0] setup;
        logic [2:0] ratio_d1;
        logic [2:0] ratio_d2;
        logic ref_q;
        logic primed;
        logic [FIFO_DEPTH-1:0][DATA_W-1:0] fifo;
        logic [ACC_W-1:0] acc;
        logic [5:0] cnt;
        logic [5:0] timer;
        logic seq_avg;
        logic [2:0] seq_code;
        logic [RES_W-1:0] result;
        logic [4:0] width;
        logic [RES_W-1:0] frame;
        logic [RES_W-1:0] shift;
        logic sdo;
        logic sdo_oe;
        logic conv_start;
        logic ready;
    } oavg_regs_t;

    oavg_regs_t st_r;
    oavg_regs_t st_nxt;
    logic rst_n;
    logic cs_s;
    logic sclk_s;

    // --------------------------------------------------------------
    // Reset release and pin capture
    // --------------------------------------------------------------
    oavg_sync #(.RST_VAL(1'b0)) u_rst_sync (
        .clk(ref_clk),
        .rst_n(nrst),
        .d(1'b1),
        .q(rst_n)
    );
    oavg_sync #(.RST_VAL(1'b1)) u_cs_sync (
        .clk(ref_clk),
        .rst_n(rst_n),
        .d(cs_n),
        .q(cs_s)
    );
    oavg_sync #(.RST_VAL(1'b0)) u_sclk_sync (
        .clk(ref_clk),
        .rst_n(rst_n),
        .d(sclk),
        .q(sclk_s)
    );

    // --------------------------------------------------------------
    // Mode decode
    // --------------------------------------------------------------
    logic style;
    logic boost_en;
    logic normal_ok;
    logic roll_ok;
    logic cs_fall;
    logic sclk_fall;

    assign style = st_r.setup[STYLE_BIT];
    assign boost_en = st_r.setup[BOOST_BIT];
    assign normal_ok = (style == STYLE_NORMAL) && (st_r.ratio_d2 != RATIO_OFF)
        && (st_r.ratio_d2 <= RATIO_MAX_NORMAL);
    assign roll_ok = (style == STYLE_ROLLING) && (st_r.ratio_d2 != RATIO_OFF)
        && (st_r.ratio_d2 <= RATIO_MAX_ROLLING);
    assign cs_fall = st_r.cs_q && !cs_s;
    assign sclk_fall = st_r.sclk_q && !sclk_s;

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb
    begin
        logic signed [ACC_W-1:0] sum_roll;
        logic signed [ACC_W-1:0] sum_sel;
        logic signed [WK_W-1:0] scaled;
        logic signed [WK_W-1:0] quot;
        logic [2:0] sh;
        logic boost;
        logic [4:0] w;
        logic [5:0] need;
        logic start;
        sum_roll = '0;
        sum_sel = '0;
        scaled = '0;
        quot = '0;
        sh = RATIO_OFF;
        boost = 1'b0;
        w = WIDTH_WIDE;
        need = 6'h01;
        start = 1'b0;
        st_nxt = st_r;
        st_nxt.cs_q = cs_s;
        st_nxt.sclk_q = sclk_s;
        st_nxt.conv_start = 1'b0;
        st_nxt.ready = 1'b0;
        st_nxt.sdo_oe = !cs_s;

        if (setup_load)
        begin
            st_nxt.setup = setup_word;
        end
        st_nxt.ratio_d1 = st_r.setup[RATIO_HI:RATIO_LO];
        st_nxt.ratio_d2 = st_r.ratio_d1;
        st_nxt.ref_q = st_r.setup[REFERENCE_SOURCE_SELECT_BIT];

        if (st_r.timer != TIMER_MAX)
        begin
            st_nxt.timer = st_r.timer + 6'h01;
        end

        // Every conversion enters the FIFO
        if (conv_done)
        begin
            if (!st_r.primed)
            begin
                st_nxt.fifo = {FIFO_DEPTH{conv_data}};
            end
            else
            begin
                st_nxt.fifo = {st_r.fifo[FIFO_DEPTH-2:0], conv_data};
            end
            st_nxt.primed = 1'b1;
        end
        // Refill request beats a same-cycle conversion
        if (soft_reset_req || (st_r.ref_q != st_r.setup[REFERENCE_SOURCE_SELECT_BIT]))
        begin
            st_nxt.primed = 1'b0;
        end

        // Sequencer
        unique case (st_r.state)
            ST_IDLE:
            begin
                if (cs_fall)
                begin
                    start = 1'b1;
                    st_nxt.seq_avg = normal_ok;
                    st_nxt.seq_code = st_r.ratio_d2;
                    st_nxt.acc = '0;
                    st_nxt.cnt = '0;
                    st_nxt.state = ST_CONV;
                end
            end
            ST_CONV:
            begin
                if (conv_done)
                begin
                    if (st_r.seq_avg)
                    begin
                        need = 6'h01 << st_r.seq_code;
                        st_nxt.acc = st_r.acc + {{(ACC_W-DATA_W){conv_data[DATA_W-1]}}, conv_data};
                        st_nxt.cnt = st_r.cnt + 6'h01;
                        if (st_r.cnt + 6'h01 == need)
                        begin
                            st_nxt.state = ST_FINISH;
                        end
                        else if (st_r.timer >= SAMPLE_CYC - 6'h01)
                        begin
                            start = 1'b1;
                        end
                        else
                        begin
                            st_nxt.state = ST_WAIT;
                        end
                    end
                    else
                    begin
                        st_nxt.state = ST_FINISH;
                    end
                end
            end
            ST_WAIT:
            begin
                if (st_r.timer >= SAMPLE_CYC - 6'h01)
                begin
                    start = 1'b1;
                    st_nxt.state = ST_CONV;
                end
            end
            ST_FINISH:
            begin
                for (int i = 0; i < FIFO_DEPTH; i++)
                begin
                    if (i < (1 << st_r.ratio_d2))
                    begin
                        sum_roll = sum_roll + {{(ACC_W-DATA_W){st_r.fifo[i][DATA_W-1]}}, st_r.fifo[i]};
                    end
                end
                if (st_r.seq_avg)
                begin
                    sum_sel = signed'(st_r.acc);
                    sh = st_r.seq_code;
                    boost = boost_en;
                end
                else if (roll_ok)
                begin
                    sum_sel = sum_roll;
                    sh = st_r.ratio_d2;
                    boost = boost_en;
                end
                else
                begin
                    sum_sel = {{(ACC_W-DATA_W){st_r.fifo[0][DATA_W-1]}}, st_r.fifo[0]};
                end
                scaled = {{(WK_W-ACC_W){sum_sel[ACC_W-1]}}, sum_sel};
                if (boost)
                begin
                    scaled = scaled <<< BOOST_BITS;
                end
                quot = scaled >>> sh;
                w = narrow_variant ? WIDTH_NARROW : WIDTH_WIDE;
                if (boost)
                begin
                    w = w + 5'(BOOST_BITS);
                end
                st_nxt.result = quot[RES_W-1:0];
                st_nxt.width = w;
                st_nxt.frame = quot[RES_W-1:0] << (5'(RES_W) - w);
                st_nxt.ready = 1'b1;
                st_nxt.acc = '0;
                st_nxt.cnt = '0;
                st_nxt.state = ST_IDLE;
            end
        endcase

        if (start)
        begin
            st_nxt.conv_start = 1'b1;
            st_nxt.timer = '0;
        end

        // Serial readback of the held result
        if (cs_fall)
        begin
            st_nxt.shift = st_r.frame;
            st_nxt.sdo = st_r.frame[RES_W-1];
        end
        else if (!cs_s && sclk_fall)
        begin
            st_nxt.shift = st_r.shift << 1;
            st_nxt.sdo = st_r.shift[RES_W-2];
        end
        else if (cs_s)
        begin
            st_nxt.sdo = 1'b0;
        end

        if (soft_reset_req)
        begin
            st_nxt.state = ST_IDLE;
            st_nxt.acc = '0;
            st_nxt.cnt = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign conv_start = st_r.conv_start;
    assign sdo = st_r.sdo;
    assign sdo_oe = st_r.sdo_oe;
    assign result_word = st_r.result;
    assign result_width = st_r.width;
    assign result_ready = st_r.ready;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_idle_fall;
        st_r.state == ST_IDLE && cs_fall && !soft_reset_req;
    endsequence
    sequence s_start_pulse;
        st_r.conv_start && st_r.state == ST_CONV;
    endsequence
    AST_START_ON_FALL: assert property (s_idle_fall |=> s_start_pulse)
        else $error("no conversion start after chip-select fall");
    AST_FIFO_PUSH: assert property (
        conv_done && st_r.primed |=> st_r.fifo[0] == $past(conv_data) && st_r.fifo[1] == $past(st_r.fifo[0]))
        else $error("conversion not shifted into fifo");
    AST_FIFO_FILL: assert property (
        conv_done && !st_r.primed |=> st_r.fifo == {FIFO_DEPTH{$past(conv_data)}})
        else $error("fifo not filled on first conversion");
    AST_RATIO_LATENCY: assert property (st_r.ratio_d2 == $past(st_r.setup[RATIO_HI:RATIO_LO], 2))
        else $error("ratio setting latency is not two clocks");
    AST_SAMPLE_GAP: assert property (
        st_r.conv_start && $past(st_r.state) != ST_IDLE |-> $past(st_r.timer) >= SAMPLE_CYC - 6'h01)
        else $error("internal sample spacing too short");
    AST_NORMAL_COUNT: assert property (
        st_r.state == ST_FINISH && st_r.seq_avg |-> st_r.cnt == (6'h01 << st_r.seq_code))
        else $error("normal average used wrong sample count");
    AST_DISCARD: assert property (
        st_r.state == ST_FINISH |=> st_r.acc == '0 && st_r.cnt == '0 && st_r.ready)
        else $error("samples not discarded after result");
    AST_RAW_RESULT: assert property (
        st_r.state == ST_FINISH && !st_r.seq_avg && !roll_ok |=> st_r.result == RES_W'(signed'($past(st_r.fifo[0]))))
        else $error("invalid code did not give raw result");
    AST_READ_MSB: assert property (
        cs_fall |=> st_r.sdo == $past(st_r.frame[RES_W-1]) && st_r.sdo_oe)
        else $error("readback did not start with msb");
    AST_WIDTH: assert property (
        st_r.ready |-> st_r.width == WIDTH_WIDE || st_r.width == WIDTH_NARROW || st_r.width == WIDTH_WIDE + 5'h02)
        else $error("illegal result width");
endmodule
`default_nettype wire
